// file: bench/tmc_host_model.sv
// host controller model issuing link commands
`timescale 1ns/100ps

module tmc_host_model (
	input  wire logic		link_clk_i,
	input  wire logic		link_cmd_ready_i,
	input  wire logic		link_rdata_valid_i,
	input  wire logic [7:0]		link_rdata_i,
	output logic			link_cmd_valid_o,
	output tmc_pkg::tmc_link_cmd_type	link_cmd_o
);
	initial
	begin
		link_cmd_valid_o = 1'b0;
		link_cmd_o = '0;
	end

	// ready checked mid-cycle; released data inverted to expose late captures
	task automatic send(input tmc_pkg::tmc_cmd_kind_type kind, input logic [7:0] data);
		int guard;
		guard = 0;
		@(posedge link_clk_i);
		link_cmd_valid_o <= 1'b1;
		link_cmd_o <= {kind, data};
		@(negedge link_clk_i);
		while (!link_cmd_ready_i && guard < 50)
		begin
			guard++;
			@(negedge link_clk_i);
		end
		@(posedge link_clk_i);
		link_cmd_valid_o <= 1'b0;
		link_cmd_o <= {kind, ~data};
	endtask : send

	task automatic read(output logic [7:0] data);
		int guard;
		send(tmc_pkg::TMC_CMD_READ, 8'h00);
		for (guard = 0; guard < 20 && !link_rdata_valid_i; guard++)
			@(negedge link_clk_i);
		data = link_rdata_valid_i ? link_rdata_i : 8'hxx;
	endtask : read

	task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
		send(tmc_pkg::TMC_CMD_POINTER, ptr);
		send(tmc_pkg::TMC_CMD_WRITE, data);
	endtask : wr

	task automatic rd(input logic [7:0] ptr, output logic [7:0] data);
		send(tmc_pkg::TMC_CMD_POINTER, ptr);
		read(data);
	endtask : rd
endmodule : tmc_host_model

// file: bench/tmc_rc_props.sv
// port checks of the temperature monitor register control
`timescale 1ns/100ps

module tmc_rc_props #(
	parameter int unsigned TICK_CYCLES = 50
) (
	input wire logic			clock_i,
	input wire logic			srst_i,
	input wire logic			ce_i,
	input wire logic			link_clk_i,
	input wire logic			link_srst_i,
	input wire logic			link_cmd_valid_i,
	input wire tmc_pkg::tmc_link_cmd_type	link_cmd_i,
	input wire logic			link_cmd_ready_o,
	input wire logic			link_rdata_valid_o,
	input wire logic [7:0]			link_rdata_o,
	input wire logic			conv_start_o,
	input wire logic			conv_valid_i,
	input wire tmc_pkg::tmc_conv_result_type	conv_result_i,
	input wire logic			overtemp_comparator_out_o,
	input wire logic			overtemp_comparator_oe_n_o,
	input wire logic			dual_pin_out_o,
	input wire logic			dual_pin_oe_n_o
);
	// ----------------------------------------------------------------
	// cycles since the last conversion start
	// ----------------------------------------------------------------
	logic [31:0]	gap_reg;
	logic [31:0]	gap_next;
	logic		seen_reg;
	assign gap_next = conv_start_o ? 32'h0000_0000 : gap_reg + 32'h0000_0001;
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			gap_reg <= 32'h0000_0000;
			seen_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			gap_reg <= gap_next;
			seen_reg <= seen_reg | conv_start_o;
		end
	end

	// ----------------------------------------------------------------
	// link side
	// ----------------------------------------------------------------
	sequence take_s;
		link_cmd_valid_i && link_cmd_ready_o;
	endsequence
	sequence read_take_s;
		take_s and (link_cmd_i.kind == tmc_pkg::TMC_CMD_READ);
	endsequence

	read_answer_a: assert property (@(posedge link_clk_i) disable iff (link_srst_i)
		read_take_s |-> ##[2:12] link_rdata_valid_o) else $error("read not answered");
	ready_hold_a: assert property (@(posedge link_clk_i) disable iff (link_srst_i)
		take_s |=> !link_cmd_ready_o [*2]) else $error("ready back too soon");
	answer_pulse_a: assert property (@(posedge link_clk_i) disable iff (link_srst_i)
		link_rdata_valid_o |=> !link_rdata_valid_o) else $error("answer flag too long");
	answer_hold_a: assert property (@(posedge link_clk_i) disable iff (link_srst_i)
		!link_rdata_valid_o |-> $stable(link_rdata_o)) else $error("read data moved");

	// ----------------------------------------------------------------
	// core side
	// ----------------------------------------------------------------
	reset_idle_a: assert property (@(posedge clock_i) disable iff (srst_i)
		$fell(srst_i) |-> overtemp_comparator_oe_n_o && dual_pin_oe_n_o && !conv_start_o)
		else $error("outputs active out of reset");
	open_drain_a: assert property (@(posedge clock_i) disable iff (srst_i)
		!overtemp_comparator_out_o && !dual_pin_out_o) else $error("pin data not low");
	start_pulse_a: assert property (@(posedge clock_i) disable iff (srst_i)
		conv_start_o |=> !conv_start_o) else $error("start pulse too long");
	start_gap_a: assert property (@(posedge clock_i) disable iff (srst_i)
		conv_start_o && seen_reg |-> gap_reg >= TICK_CYCLES - 1) else $error("starts too close");
endmodule : tmc_rc_props

bind tmc_register_control tmc_rc_props #(.TICK_CYCLES(TICK_CYCLES)) props_u (
	.clock_i, .srst_i, .ce_i, .link_clk_i, .link_srst_i, .link_cmd_valid_i, .link_cmd_i,
	.link_cmd_ready_o, .link_rdata_valid_o, .link_rdata_o, .conv_start_o, .conv_valid_i,
	.conv_result_i, .overtemp_comparator_out_o, .overtemp_comparator_oe_n_o,
	.dual_pin_out_o, .dual_pin_oe_n_o);

// file: bench/tmc_register_control_bench.sv
// self-checking bench of the temperature monitor register control
`timescale 1ns/100ps

`define CHK(got, exp) \
	begin \
		n_tests++; \
		if ((got) !== (exp)) \
		begin \
			mismatches++; \
			$display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
		end \
	end

module tmc_register_control_bench;
	localparam int unsigned TICK = 50;
	logic		clock_i;
	logic		link_clk_i;
	logic		srst_i;
	logic		link_srst_i;
	logic		conv_valid_i;
	tmc_pkg::tmc_conv_result_type	conv_result_i;
	tmc_pkg::tmc_link_cmd_type	cmd;
	logic		cmd_valid;
	logic		ready;
	logic		rvalid;
	logic [7:0]	rdata;
	logic		conv_start;
	logic		ot_oe_n;
	logic		dp_oe_n;
	logic [7:0]	rd_val;
	int		mismatches;
	int		n_tests;
	int		starts;
	int		n;
	logic [7:0]	rst_ptr[6] = '{8'h10, 8'h01, 8'h03, 8'h04, 8'h21, 8'h02};
	logic [7:0]	rst_val[6] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h0A, 8'h00};

	tmc_register_control #(.TICK_CYCLES(TICK)) dut_u (
		.clock_i(clock_i), .srst_i(srst_i), .ce_i(1'b1), .link_clk_i(link_clk_i),
		.link_srst_i(link_srst_i), .link_cmd_valid_i(cmd_valid), .link_cmd_i(cmd),
		.link_cmd_ready_o(ready), .link_rdata_valid_o(rvalid), .link_rdata_o(rdata),
		.conv_start_o(conv_start), .conv_valid_i(conv_valid_i), .conv_result_i(conv_result_i),
		.overtemp_comparator_out_o(), .overtemp_comparator_oe_n_o(ot_oe_n),
		.dual_pin_out_o(), .dual_pin_oe_n_o(dp_oe_n));

	tmc_host_model host_u (
		.link_clk_i(link_clk_i), .link_cmd_ready_i(ready), .link_rdata_valid_i(rvalid),
		.link_rdata_i(rdata), .link_cmd_valid_o(cmd_valid), .link_cmd_o(cmd));

	initial
	begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	initial
	begin
		link_clk_i = 1'b0;
		#5.3;
		forever #16 link_clk_i = ~link_clk_i;
	end
	always @(posedge clock_i)
		if (conv_start === 1'b1)
			starts++;

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	task automatic chk_reg(input logic [7:0] ptr, input logic [7:0] exp);
		host_u.rd(ptr, rd_val);
		`CHK(rd_val, exp)
	endtask : chk_reg

	task automatic conv(input logic signed [9:0] loc, input logic signed [11:0] rem);
		@(posedge clock_i);
		conv_valid_i <= 1'b1;
		conv_result_i <= {loc, rem};
		@(posedge clock_i);
		conv_valid_i <= 1'b0;
		conv_result_i <= ~{loc, rem};
	endtask : conv

	// writes land a few core cycles after the take
	task automatic pins(input logic ot, input logic dp);
		repeat (2) @(posedge link_clk_i);
		#1;
		`CHK(ot_oe_n, ot)
		`CHK(dp_oe_n, dp)
	endtask : pins

	// start-to-start cycles
	task automatic gap();
		n = 0;
		while (conv_start !== 1'b1 && n < 5000)
		begin
			@(posedge clock_i);
			#1;
			n++;
		end
		n = 0;
		do
		begin
			@(posedge clock_i);
			#1;
			n++;
		end while (conv_start !== 1'b1 && n < 5000);
	endtask : gap

	initial
	begin
		#200000;
		mismatches++;
		$display("Error at %0t: watchdog expired", $time);
		print_verdict();
	end

	initial
	begin
		srst_i = 1'b1;
		link_srst_i = 1'b1;
		conv_valid_i = 1'b0;
		conv_result_i = '0;
		repeat (4) @(posedge link_clk_i);
		link_srst_i <= 1'b0;
		@(posedge clock_i);
		srst_i <= 1'b0;
		host_u.read(rd_val);
		`CHK(rd_val, 8'h00)
		foreach (rst_ptr[i])
			chk_reg(rst_ptr[i], rst_val[i]);
		$display("reset values done");
		conv(-10'sd5, 12'sd101);
		chk_reg(8'h00, 8'h00);
		chk_reg(8'h10, 8'h40);
		conv(10'sd200, 12'sd603);
		chk_reg(8'h01, 8'h19);
		chk_reg(8'h00, 8'h7F);
		conv(10'sd200, 12'sd603);
		chk_reg(8'h10, 8'h00);
		chk_reg(8'h01, 8'h7F);
		host_u.wr(8'h09, 8'h04);
		chk_reg(8'h03, 8'h04);
		chk_reg(8'h05, 8'h55);
		conv(-10'sd55, 12'sd603);
		chk_reg(8'h00, 8'h09);
		chk_reg(8'h10, 8'hC0);
		chk_reg(8'h01, 8'hD6);
		host_u.wr(8'h00, 8'hAA);
		chk_reg(8'h00, 8'h09);
		host_u.wr(8'h09, 8'h00);
		$display("formats done");
		conv(10'sd90, 12'sd160);
		pins(1'b0, 1'b0);
		conv(10'sd80, 12'sd160);
		pins(1'b0, 1'b0);
		conv(10'sd75, 12'sd160);
		host_u.send(tmc_pkg::TMC_CMD_ALERT_ACK, 8'h00);
		pins(1'b1, 1'b1);
		conv(10'sd0, 12'sd160);
		pins(1'b1, 1'b0);
		host_u.wr(8'h09, 8'h80);
		pins(1'b1, 1'b1);
		host_u.wr(8'h09, 8'h20);
		conv(10'sd86, 12'sd160);
		pins(1'b0, 1'b0);
		conv(10'sd40, 12'sd160);
		pins(1'b1, 1'b1);
		$display("comparators done");
		conv(10'sd90, 12'sd160);
		host_u.wr(8'h09, 8'h60);
		host_u.wr(8'h20, 8'h64);
		starts = 0;
		pins(1'b1, 1'b0);
		repeat (600) @(posedge clock_i);
		`CHK(starts, 0)
		host_u.wr(8'h09, 8'h00);
		for (int c = 10; c >= 8; c--)
		begin
			host_u.wr(8'h0A, 8'(c));
			chk_reg(8'h04, 8'(c));
			gap();
			gap();
			`CHK(n, int'(TICK) << (10 - c))
		end
		$display("pacing done");
		print_verdict();
	end
endmodule : tmc_register_control_bench

// file: rtl/tmc_cdc_xfer.sv
// toggle handshake carrying one word between two clock domains
`timescale 1ns/100ps

module tmc_cdc_xfer #(
	parameter int WIDTH = 8
) (
	input  wire logic             src_clk_i,
	input  wire logic             src_srst_i,
	input  wire logic             src_ce_i,
	input  wire logic             src_valid_i,
	input  wire logic [WIDTH-1:0] src_data_i,
	output logic                  src_ready_o,
	input  wire logic             dst_clk_i,
	input  wire logic             dst_srst_i,
	input  wire logic             dst_ce_i,
	output logic                  dst_valid_o,
	output logic [WIDTH-1:0]      dst_data_o
);

	logic             req_reg;
	logic [WIDTH-1:0] hold_reg;
	logic             ack_meta_reg;
	logic             ack_sync_reg;
	logic             req_meta_reg;
	logic             req_sync_reg;
	logic             req_seen_reg;
	logic             dst_valid_reg;
	logic [WIDTH-1:0] dst_data_reg;

	// ----------------------------------------------------------------
	// source side: word held still until the far side has echoed the toggle
	// ----------------------------------------------------------------
	assign src_ready_o = (ack_sync_reg == req_reg);

	always_ff @(posedge src_clk_i)
	begin
		if (src_srst_i)
		begin
			req_reg      <= 1'b0;
			hold_reg     <= '0;
			ack_meta_reg <= 1'b0;
			ack_sync_reg <= 1'b0;
		end
		else if (src_ce_i)
		begin
			ack_meta_reg <= req_seen_reg;
			ack_sync_reg <= ack_meta_reg;
			if (src_valid_i && src_ready_o)
			begin
				req_reg  <= ~req_reg;
				hold_reg <= src_data_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// destination side: the synchronised toggle marks a stable word
	// ----------------------------------------------------------------
	always_ff @(posedge dst_clk_i)
	begin
		if (dst_srst_i)
		begin
			req_meta_reg  <= 1'b0;
			req_sync_reg  <= 1'b0;
			req_seen_reg  <= 1'b0;
			dst_valid_reg <= 1'b0;
			dst_data_reg  <= '0;
		end
		else if (dst_ce_i)
		begin
			req_meta_reg  <= req_reg;
			req_sync_reg  <= req_meta_reg;
			req_seen_reg  <= req_sync_reg;
			dst_valid_reg <= (req_sync_reg != req_seen_reg);
			if (req_sync_reg != req_seen_reg)
				dst_data_reg <= hold_reg;
		end
	end

	assign dst_valid_o = dst_valid_reg;
	assign dst_data_o  = dst_data_reg;

endmodule : tmc_cdc_xfer

// file: rtl/tmc_consts.svh
// offsets, reset values, fields and timing of the temperature monitor
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

// ----------------------------------------------------------------
// register pointer values
// ----------------------------------------------------------------
`define TMC_OFF_LOCAL_RES      8'h00
`define TMC_OFF_REMOTE_RES_HI  8'h01
`define TMC_OFF_CFG_RD         8'h03
`define TMC_OFF_RATE_RD        8'h04
`define TMC_OFF_LHI_RD         8'h05
`define TMC_OFF_LLO_RD         8'h06
`define TMC_OFF_RHI_HI_RD      8'h07
`define TMC_OFF_RLO_HI_RD      8'h08
`define TMC_OFF_CFG_WR         8'h09
`define TMC_OFF_RATE_WR        8'h0A
`define TMC_OFF_LHI_WR         8'h0B
`define TMC_OFF_LLO_WR         8'h0C
`define TMC_OFF_RHI_HI_WR      8'h0D
`define TMC_OFF_RLO_HI_WR      8'h0E
`define TMC_OFF_REMOTE_RES_LO  8'h10
`define TMC_OFF_RHI_LO         8'h13
`define TMC_OFF_RLO_LO         8'h14
`define TMC_OFF_RTHERM         8'h19
`define TMC_OFF_LTHERM         8'h20
`define TMC_OFF_HYST           8'h21

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TMC_RST_PTR            8'h00
`define TMC_RST_RESULT         8'h00
`define TMC_RST_CFG            8'h00
`define TMC_RST_RATE           8'h08
`define TMC_RST_HIGH_LIM       8'h55
`define TMC_RST_LOW_LIM        8'h00
`define TMC_RST_OVERTEMP_COMPARATOR_OUT_LIM      8'h55
`define TMC_RST_HYST           8'h0A
`define TMC_UNMAPPED_READ      8'h00

// ----------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------
`define TMC_CFG_MASK_BIT       7
`define TMC_CFG_STANDBY_BIT    6
`define TMC_CFG_PINSEL_BIT     5
`define TMC_CFG_RANGE_BIT      2
`define TMC_CFG_USED_BITS      8'hE4
`define TMC_RATE_CODE_MAX      4'hA
`define TMC_OFFSET_BIN_DEG     11'sh040

// ----------------------------------------------------------------
// timing: fastest interval, clock period
// ----------------------------------------------------------------
`define TMC_FAST_INTERVAL_MS   15.5
`define TMC_CLOCK_PERIOD_NS    4.0

`endif

// file: rtl/tmc_pkg.sv
// types shared by the temperature monitor register control
package tmc_pkg;

	// ----------------------------------------------------------------
	// link commands
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		TMC_CMD_POINTER,
		TMC_CMD_WRITE,
		TMC_CMD_READ,
		TMC_CMD_ALERT_ACK
	} tmc_cmd_kind_type;

	typedef struct packed {
		tmc_cmd_kind_type kind;
		logic [7:0]       data;
	} tmc_link_cmd_type;

	// ----------------------------------------------------------------
	// front end results: whole degrees and quarter degrees, signed
	// ----------------------------------------------------------------
	typedef struct packed {
		logic signed [9:0]  local_deg;
		logic signed [11:0] remote_qdeg;
	} tmc_conv_result_type;

endpackage : tmc_pkg

// file: rtl/tmc_register_control.sv
// register set, conversion pacing and limit comparators of a dual-channel temperature monitor
//
// What this block does
// RULE_01: extended range results and limits use offset-64
// RULE_02: default range clamps results to 0..127
// RULE_03: range change affects next result, not limits
// RULE_04: first written byte loads pointer, second writes
// RULE_05: pointer resets to local result address
// RULE_06: result registers read-only, conversion-written, reset zero
// RULE_07: configuration read 0x03, written 0x09, reset zero
// RULE_08: bit 7 masks alarm pin in alarm mode
// RULE_09: bit 6 standby stops conversions, outputs still live
// RULE_10: standby writes re-evaluate outputs at once
// RULE_11: bit 5 picks alarm or second comparator
// RULE_12: bit 2 selects default or extended range
// RULE_13: rate read 0x04, written 0x0A, reset 0x08
// RULE_14: rate code halves interval, codes above 0x0A reserved
// RULE_15: host writes zeros to upper rate bits
// RULE_16: each interval converts local and remote channel
// RULE_17: above high or at/below low sets flag
// RULE_18: overtemp output low when either exceeds limit
// RULE_19: second comparator low when high limit exceeded
// RULE_20: one hysteresis register, default 10, both channels
// RULE_21: limits compared raw; host re-encodes after range change
// RULE_22: eight limit registers, remote high/low two bytes
// RULE_23: overtemp releases at limit minus hysteresis
// RULE_24: remote low read freezes high byte until read
// RULE_25: results arrive as words with strobe
`timescale 1ns/100ps
`include "tmc_consts.svh"

module tmc_register_control #(
	parameter int unsigned TICK_CYCLES =
		$rtoi(`TMC_FAST_INTERVAL_MS * 1.0e6 / `TMC_CLOCK_PERIOD_NS)
) (
	input  wire logic                         clock_i,
	input  wire logic                         srst_i,
	input  wire logic                         ce_i,
	input  wire logic                         link_clk_i,
	input  wire logic                         link_srst_i,
	input  wire logic                         link_cmd_valid_i,
	input  wire tmc_pkg::tmc_link_cmd_type    link_cmd_i,
	output logic                              link_cmd_ready_o,
	output logic                              link_rdata_valid_o,
	output logic [7:0]                        link_rdata_o,
	output logic                              conv_start_o,
	input  wire logic                         conv_valid_i,
	input  wire tmc_pkg::tmc_conv_result_type conv_result_i,
	output logic                              overtemp_comparator_out_o,
	output logic                              overtemp_comparator_oe_n_o,
	output logic                              dual_pin_out_o,
	output logic                              dual_pin_oe_n_o
);

	localparam int CMD_W = $bits(tmc_pkg::tmc_link_cmd_type);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// quarter-degree reading to {integer code, two fraction bits}
	function automatic logic [9:0] tmc_encode(input logic signed [11:0] qdeg,
		input logic ext);
		logic signed [10:0] v;
		v = 11'(qdeg >>> 2);
		if (ext)
			v = v + `TMC_OFFSET_BIN_DEG; // RULE_01
		if (v < 0)
			return 10'h000; // RULE_02
		else if (!ext && v > 11'sh07F)
			return {8'h7F, 2'b00}; // RULE_02
		else if (v > 11'sh0FF)
			return {8'hFF, 2'b00};
		else
			return {v[7:0], qdeg[1:0]};
	endfunction : tmc_encode

	// release at or below limit minus hysteresis, trip above limit
	function automatic logic tmc_hyst(input logic cur, input logic [7:0] temp,
		input logic [7:0] lim, input logic [7:0] hyst);
		logic signed [9:0] rel;
		rel = $signed({2'b00, lim}) - $signed({2'b00, hyst});
		if (temp > lim)
			return 1'b1; // RULE_18
		else if ($signed({2'b00, temp}) <= rel)
			return 1'b0; // RULE_23
		else
			return cur;
	endfunction : tmc_hyst

	// ----------------------------------------------------------------
	// link crossings
	// ----------------------------------------------------------------
	logic                       cmd_pulse;
	tmc_pkg::tmc_link_cmd_type  cmd;
	logic [CMD_W-1:0]           cmd_bits;
	logic                       rd_pulse_reg;
	logic [7:0]                 rd_data_reg;

	tmc_cdc_xfer #(
		.WIDTH (CMD_W)
	) u_cmd_xfer (
		.src_clk_i   (link_clk_i),
		.src_srst_i  (link_srst_i),
		.src_ce_i    (1'b1),
		.src_valid_i (link_cmd_valid_i),
		.src_data_i  (link_cmd_i),
		.src_ready_o (link_cmd_ready_o),
		.dst_clk_i   (clock_i),
		.dst_srst_i  (srst_i),
		.dst_ce_i    (ce_i),
		.dst_valid_o (cmd_pulse),
		.dst_data_o  (cmd_bits)
	);

	assign cmd = tmc_pkg::tmc_link_cmd_type'(cmd_bits);

	// link ready returns at least one link cycle before this read is answered
	tmc_cdc_xfer #(
		.WIDTH (8)
	) u_rdata_xfer (
		.src_clk_i   (clock_i),
		.src_srst_i  (srst_i),
		.src_ce_i    (ce_i),
		.src_valid_i (rd_pulse_reg),
		.src_data_i  (rd_data_reg),
		.src_ready_o (),
		.dst_clk_i   (link_clk_i),
		.dst_srst_i  (link_srst_i),
		.dst_ce_i    (1'b1),
		.dst_valid_o (link_rdata_valid_o),
		.dst_data_o  (link_rdata_o)
	);

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [7:0] ptr_reg;
	logic [7:0] local_res_reg;
	logic [7:0] remote_hi_reg;
	logic [7:0] remote_lo_reg;
	logic [7:0] cfg_reg;
	logic [7:0] rate_reg;
	logic [7:0] lhi_reg;
	logic [7:0] llo_reg;
	logic [7:0] rhi_hi_reg;
	logic [7:0] rhi_lo_reg;
	logic [7:0] rlo_hi_reg;
	logic [7:0] rlo_lo_reg;
	logic [7:0] ltherm_reg;
	logic [7:0] rtherm_reg;
	logic [7:0] hyst_reg;
	logic       freeze_reg;

	wire is_ptr   = cmd_pulse && (cmd.kind == tmc_pkg::TMC_CMD_POINTER);
	wire is_write = cmd_pulse && (cmd.kind == tmc_pkg::TMC_CMD_WRITE);
	wire is_read  = cmd_pulse && (cmd.kind == tmc_pkg::TMC_CMD_READ);
	wire is_ack   = cmd_pulse && (cmd.kind == tmc_pkg::TMC_CMD_ALERT_ACK);

	wire ext_range = cfg_reg[`TMC_CFG_RANGE_BIT]; // RULE_12
	wire standby   = cfg_reg[`TMC_CFG_STANDBY_BIT];
	wire pin_sel   = cfg_reg[`TMC_CFG_PINSEL_BIT];
	wire alarm_msk = cfg_reg[`TMC_CFG_MASK_BIT];

	// ----------------------------------------------------------------
	// read selection
	// ----------------------------------------------------------------
	wire [7:0] rd_sel =
		(ptr_reg == `TMC_OFF_LOCAL_RES)     ? local_res_reg :
		(ptr_reg == `TMC_OFF_REMOTE_RES_HI) ? remote_hi_reg :
		(ptr_reg == `TMC_OFF_REMOTE_RES_LO) ? remote_lo_reg :
		(ptr_reg == `TMC_OFF_CFG_RD)        ? cfg_reg :
		(ptr_reg == `TMC_OFF_RATE_RD)       ? rate_reg :
		(ptr_reg == `TMC_OFF_LHI_RD)        ? lhi_reg :
		(ptr_reg == `TMC_OFF_LLO_RD)        ? llo_reg :
		(ptr_reg == `TMC_OFF_RHI_HI_RD)     ? rhi_hi_reg :
		(ptr_reg == `TMC_OFF_RLO_HI_RD)     ? rlo_hi_reg :
		(ptr_reg == `TMC_OFF_RHI_LO)        ? rhi_lo_reg :
		(ptr_reg == `TMC_OFF_RLO_LO)        ? rlo_lo_reg :
		(ptr_reg == `TMC_OFF_LTHERM)        ? ltherm_reg :
		(ptr_reg == `TMC_OFF_RTHERM)        ? rtherm_reg :
		(ptr_reg == `TMC_OFF_HYST)          ? hyst_reg :
		`TMC_UNMAPPED_READ;

	// ----------------------------------------------------------------
	// pointer, writes and read answers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			ptr_reg      <= `TMC_RST_PTR; // RULE_05
			rd_pulse_reg <= 1'b0;
			rd_data_reg  <= 8'h00;
		end
		else if (ce_i)
		begin
			rd_pulse_reg <= is_read;
			if (is_ptr)
				ptr_reg <= cmd.data; // RULE_04
			if (is_read)
				rd_data_reg <= rd_sel; // RULE_04
		end
	end

	// result addresses take no write; limits survive range changes
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			cfg_reg    <= `TMC_RST_CFG; // RULE_07
			rate_reg   <= `TMC_RST_RATE; // RULE_13
			lhi_reg    <= `TMC_RST_HIGH_LIM;
			llo_reg    <= `TMC_RST_LOW_LIM;
			rhi_hi_reg <= `TMC_RST_HIGH_LIM;
			rhi_lo_reg <= `TMC_RST_LOW_LIM;
			rlo_hi_reg <= `TMC_RST_LOW_LIM;
			rlo_lo_reg <= `TMC_RST_LOW_LIM;
			ltherm_reg <= `TMC_RST_OVERTEMP_COMPARATOR_OUT_LIM;
			rtherm_reg <= `TMC_RST_OVERTEMP_COMPARATOR_OUT_LIM;
			hyst_reg   <= `TMC_RST_HYST; // RULE_20
		end
		else if (ce_i && is_write)
		begin
			case (ptr_reg) // RULE_22
				`TMC_OFF_CFG_WR:    cfg_reg    <= cmd.data & `TMC_CFG_USED_BITS; // RULE_07
				`TMC_OFF_RATE_WR:   rate_reg   <= cmd.data; // RULE_13
				`TMC_OFF_LHI_WR:    lhi_reg    <= cmd.data;
				`TMC_OFF_LLO_WR:    llo_reg    <= cmd.data;
				`TMC_OFF_RHI_HI_WR: rhi_hi_reg <= cmd.data;
				`TMC_OFF_RLO_HI_WR: rlo_hi_reg <= cmd.data;
				`TMC_OFF_RHI_LO:    rhi_lo_reg <= cmd.data;
				`TMC_OFF_RLO_LO:    rlo_lo_reg <= cmd.data;
				`TMC_OFF_LTHERM:    ltherm_reg <= cmd.data;
				`TMC_OFF_RTHERM:    rtherm_reg <= cmd.data;
				`TMC_OFF_HYST:      hyst_reg   <= cmd.data; // RULE_20
				default:            ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// conversion pacing
	// ----------------------------------------------------------------
	// only the low nibble counts; reserved codes run at the fastest rate
	wire [3:0] rate_code = (rate_reg[3:0] > `TMC_RATE_CODE_MAX) ?
		`TMC_RATE_CODE_MAX : rate_reg[3:0]; // RULE_14
	wire [10:0] tick_target = 11'(11'h001 << (`TMC_RATE_CODE_MAX - rate_code)); // RULE_14

	logic [31:0] pre_cnt_reg;
	logic [10:0] tick_cnt_reg;
	logic        conv_start_reg;

	wire pre_wrap  = (pre_cnt_reg == 32'(TICK_CYCLES - 1));
	wire tick_wrap = pre_wrap && (tick_cnt_reg >= tick_target - 11'h001);

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			pre_cnt_reg    <= 32'h0000_0000;
			tick_cnt_reg   <= 11'h000;
			conv_start_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			conv_start_reg <= 1'b0;
			if (standby)
			begin
				pre_cnt_reg  <= 32'h0000_0000; // RULE_09
				tick_cnt_reg <= 11'h000;
			end
			else
			begin
				pre_cnt_reg <= pre_wrap ? 32'h0000_0000 : pre_cnt_reg + 32'h0000_0001;
				if (tick_wrap)
				begin
					tick_cnt_reg   <= 11'h000;
					conv_start_reg <= 1'b1; // RULE_16
				end
				else if (pre_wrap)
					tick_cnt_reg <= tick_cnt_reg + 11'h001;
			end
		end
	end

	assign conv_start_o = conv_start_reg;

	// ----------------------------------------------------------------
	// result registers
	// ----------------------------------------------------------------
	wire [9:0] local_code  = tmc_encode({conv_result_i.local_deg, 2'b00}, ext_range); // RULE_03
	wire [9:0] remote_code = tmc_encode(conv_result_i.remote_qdeg, ext_range); // RULE_03

	wire rd_remote_lo = is_read && (ptr_reg == `TMC_OFF_REMOTE_RES_LO);
	wire rd_remote_hi = is_read && (ptr_reg == `TMC_OFF_REMOTE_RES_HI);

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			local_res_reg <= `TMC_RST_RESULT; // RULE_06
			remote_hi_reg <= `TMC_RST_RESULT;
			remote_lo_reg <= `TMC_RST_RESULT;
			freeze_reg    <= 1'b0;
		end
		else if (ce_i)
		begin
			if (rd_remote_lo)
				freeze_reg <= 1'b1; // RULE_24
			else if (rd_remote_hi)
				freeze_reg <= 1'b0;
			if (conv_valid_i) // RULE_25
			begin
				local_res_reg <= local_code[9:2]; // RULE_06
				remote_lo_reg <= {remote_code[1:0], 6'b00_0000};
				if (!freeze_reg)
					remote_hi_reg <= remote_code[9:2]; // RULE_24
			end
		end
	end

	// ----------------------------------------------------------------
	// limit comparators; evaluated every cycle, so writes in standby act at once
	// ----------------------------------------------------------------
	// codes compared raw: limits are in whatever format software wrote
	wire [9:0] remote_full = {remote_hi_reg, remote_lo_reg[7:6]}; // RULE_21
	wire [3:0] out_of_limit = {
		remote_full <= {rlo_hi_reg, rlo_lo_reg[7:6]},
		remote_full >  {rhi_hi_reg, rhi_lo_reg[7:6]},
		local_res_reg <= llo_reg,
		local_res_reg >  lhi_reg
	}; // RULE_17

	// channels: local overtemp, remote overtemp, local high, remote high
	logic [3:0] cmp_reg;
	logic [3:0] cmp_next;
	logic [7:0] ch_temp [4];
	logic [7:0] ch_lim  [4];

	assign ch_temp[0] = local_res_reg;
	assign ch_temp[1] = remote_hi_reg;
	assign ch_temp[2] = local_res_reg;
	assign ch_temp[3] = remote_hi_reg;
	assign ch_lim[0]  = ltherm_reg;
	assign ch_lim[1]  = rtherm_reg;
	assign ch_lim[2]  = lhi_reg;
	assign ch_lim[3]  = rhi_hi_reg;

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_cmp
			assign cmp_next[g] = tmc_hyst(cmp_reg[g], ch_temp[g], ch_lim[g], hyst_reg); // RULE_10
		end
	endgenerate

	// flags are sticky unless pin_sel clears them; a new excursion wins over the acknowledge
	logic [3:0] flag_reg;
	wire  [3:0] flag_keep = is_ack ? 4'h0 : flag_reg;
	wire  [3:0] flag_next = pin_sel ? 4'h0 : (flag_keep | out_of_limit); // RULE_17

	logic overtemp_reg;
	logic dual_reg;

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			cmp_reg      <= 4'h0;
			flag_reg     <= 4'h0;
			overtemp_reg <= 1'b0;
			dual_reg     <= 1'b0;
		end
		else if (ce_i)
		begin
			cmp_reg      <= cmp_next; // RULE_10
			flag_reg     <= flag_next;
			overtemp_reg <= cmp_next[0] | cmp_next[1]; // RULE_18
			if (pin_sel)
				dual_reg <= cmp_next[2] | cmp_next[3]; // RULE_19
			else
				dual_reg <= (|flag_next) & ~alarm_msk; // RULE_08 RULE_11
		end
	end

	// ----------------------------------------------------------------
	// open-drain pins: pulled low while asserted, released otherwise
	// ----------------------------------------------------------------
	assign overtemp_comparator_out_o  = 1'b0;
	assign overtemp_comparator_oe_n_o = ~overtemp_reg; // RULE_18
	assign dual_pin_out_o             = 1'b0;
	assign dual_pin_oe_n_o            = ~dual_reg; // RULE_11

endmodule : tmc_register_control
